// [rtl/eomc_regs.sv]
`timescale 1ns/1ns
module eomc_regs #(
  parameter int unsigned ADDR_W = eomc_pkg::ADDR_W
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [ADDR_W-1:0]     haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  compute_tick,
  input  wire eomc_pkg::eomc_src_type src,
  input  wire logic                  zero_cross,
  input  wire logic                  rms_ready,
  output logic                       pulse_out_a,
  output logic                       pulse_out_b,
  output logic                       apparent_energy_accum_inc,
  output logic                       rms_update,
  output logic                       period_or_freq_select,
  output logic                       waveform_sampling_enable,
  output logic                       engine_soft_reset
);

  if (ADDR_W < 8)
  begin : g_addr_check
    $error("address width too small for register map");
  end

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction : byte_addr

  // one shared choice bit feeds both outputs, so they cannot mix
  function automatic logic pick_src(input logic [1:0] sel,
                                    input logic choice,
                                    input eomc_pkg::eomc_src_type s);
    if (sel == eomc_pkg::SEL_ACTIVE)
      pick_src = s.active;
    else if (sel == eomc_pkg::SEL_REACTIVE)
      pick_src = s.reactive;
    else
      pick_src = choice ? s.current : s.apparent;
  endfunction : pick_src

  logic [ADDR_W-1:0]           addr_r;
  logic                        wr_pend_r;
  logic [7:0]                  mode_one_r;
  logic [7:0]                  mode_one_nxt;
  eomc_pkg::eomc_mode_two_type mode_two_r;
  eomc_pkg::eomc_mode_two_type mode_two_nxt;
  eomc_pkg::eomc_mode_two_type eff_r;
  eomc_pkg::eomc_mode_two_type eff_nxt;
  logic [31:0]                 hrdata_r;
  logic                        pulse_a_r;
  logic                        pulse_b_r;
  logic                        accum_r;
  logic                        rms_upd_r;
  logic                        srst_r;

  wire logic addr_ok    = hsel & hready & (htrans == eomc_pkg::HTRANS_NONSEQ);
  wire logic wr_take    = addr_ok & hwrite;
  wire logic rd_take    = addr_ok & ~hwrite;
  wire logic hit_one_w  =
    wr_pend_r & (addr_r == byte_addr(eomc_pkg::MODE_ONE_IDX));
  wire logic hit_two_w  =
    wr_pend_r & (addr_r == byte_addr(eomc_pkg::MODE_TWO_IDX));
  wire logic srst_req   = hit_one_w & hwdata[eomc_pkg::M1_SRST_BIT];
  wire logic hit_one_r  = haddr == byte_addr(eomc_pkg::MODE_ONE_IDX);
  wire logic hit_two_r  = haddr == byte_addr(eomc_pkg::MODE_TWO_IDX);
  wire logic dis_a      = mode_one_r[eomc_pkg::M1_DISA_BIT];
  wire logic dis_b      = mode_one_r[eomc_pkg::M1_DISB_BIT];

  // soft reset overrides the write that carries it; the bit never sticks
  assign mode_one_nxt =
    srst_req  ? eomc_pkg::MODE_ONE_RST :
    hit_one_w ? hwdata[7:0] : mode_one_r;
  assign mode_two_nxt =
    srst_req  ? eomc_pkg::MODE_TWO_RST :
    hit_two_w ? hwdata[7:0] : mode_two_r;
  // source selection is sampled once per compute cycle
  assign eff_nxt =
    srst_req     ? eomc_pkg::MODE_TWO_RST :
    compute_tick ? mode_two_r : eff_r;

  // forwarding the pending write keeps back-to-back read coherent
  wire logic [31:0] rd_val =
    hit_one_r ? {24'h00_0000, mode_one_nxt} :
    hit_two_r ? {24'h00_0000, mode_two_nxt} : eomc_pkg::RDATA_ZERO;

  wire logic sel_a_v = pick_src(eff_r.sel_a, eff_r.choice, src);
  wire logic sel_b_v = pick_src(eff_r.sel_b, eff_r.choice, src);
  wire logic accum_v = eff_r.choice ? src.current : src.apparent;
  wire logic rms_v   = mode_two_r.rms_zx ? zero_cross : rms_ready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r     <= '0;
      wr_pend_r  <= 1'b0;
      hrdata_r   <= eomc_pkg::RDATA_ZERO;
    end
    else
    begin
      if (hready)
      begin
        addr_r    <= haddr;
        wr_pend_r <= wr_take;
      end
      if (rd_take)
        hrdata_r <= rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_one_r <= eomc_pkg::MODE_ONE_RST;
      mode_two_r <= eomc_pkg::MODE_TWO_RST;
      eff_r      <= eomc_pkg::MODE_TWO_RST;
      srst_r     <= 1'b0;
    end
    else
    begin
      mode_one_r <= mode_one_nxt;
      mode_two_r <= mode_two_nxt;
      eff_r      <= eff_nxt;
      srst_r     <= srst_req;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pulse_a_r <= 1'b0;
      pulse_b_r <= 1'b0;
      accum_r   <= 1'b0;
      rms_upd_r <= 1'b0;
    end
    else
    begin
      pulse_a_r <= sel_a_v & ~dis_a;
      pulse_b_r <= sel_b_v & ~dis_b;
      accum_r   <= accum_v;
      rms_upd_r <= rms_v;
    end
  end

  assign hreadyout                 = 1'b1;
  assign hresp                     = 1'b0;
  assign hrdata                    = hrdata_r;
  assign pulse_out_a               = pulse_a_r;
  assign pulse_out_b               = pulse_b_r;
  assign apparent_energy_accum_inc = accum_r;
  assign rms_update                = rms_upd_r;
  assign period_or_freq_select     = mode_two_r.freq;
  assign waveform_sampling_enable  = mode_two_r.wave;
  assign engine_soft_reset         = srst_r;

  // checks: one clock domain, all quiet while reset is low
  default clocking cb_chk @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // fields of the write data phase, for checks on what gets stored
  wire eomc_pkg::eomc_mode_two_type wr_fields = hwdata[7:0];

  a_soft_reset_defaults: assert property (
    srst_req |=> mode_two_r == eomc_pkg::MODE_TWO_RST
      && mode_one_r == eomc_pkg::MODE_ONE_RST
      && eff_r == eomc_pkg::MODE_TWO_RST && engine_soft_reset)
    else $error("soft reset did not restore defaults");

  a_srst_single_pulse: assert property (
    !srst_req |=> !engine_soft_reset)
    else $error("soft reset pulse without request");

  a_srst_not_stored: assert property (
    !mode_one_r[eomc_pkg::M1_SRST_BIT])
    else $error("soft reset bit stuck in mode one");

  a_sel_b_write: assert property (
    hit_two_w |=> mode_two_r.sel_b == $past(wr_fields.sel_b))
    else $error("pulse b selector not stored");

  a_sel_b_active: assert property (
    (eff_r.sel_b == eomc_pkg::SEL_ACTIVE && !dis_b)
      |=> pulse_out_b == $past(src.active))
    else $error("pulse b not following active power");

  a_sel_b_reactive: assert property (
    (eff_r.sel_b == eomc_pkg::SEL_REACTIVE && !dis_b)
      |=> pulse_out_b == $past(src.reactive))
    else $error("pulse b not following reactive power");

  a_sel_a_active: assert property (
    (eff_r.sel_a == eomc_pkg::SEL_ACTIVE && !dis_a)
      |=> pulse_out_a == $past(src.active))
    else $error("pulse a not following active power");

  a_sel_a_reactive: assert property (
    (eff_r.sel_a == eomc_pkg::SEL_REACTIVE && !dis_a)
      |=> pulse_out_a == $past(src.reactive))
    else $error("pulse a not following reactive power");

  a_apparent_path: assert property (
    (eff_r.sel_a[1] && !eff_r.choice && !dis_a)
      |=> pulse_out_a == $past(src.apparent))
    else $error("pulse a not following apparent power");

  a_apparent_b: assert property (
    (eff_r.sel_b[1] && !eff_r.choice && !dis_b)
      |=> pulse_out_b == $past(src.apparent))
    else $error("pulse b not following apparent power");

  a_current_path: assert property (
    (eff_r.sel_b[1] && eff_r.choice && !dis_b)
      |=> pulse_out_b == $past(src.current))
    else $error("pulse b not following rms current");

  a_current_a: assert property (
    (eff_r.sel_a[1] && eff_r.choice && !dis_a)
      |=> pulse_out_a == $past(src.current))
    else $error("pulse a not following rms current");

  a_accum_source: assert property (
    eff_r.choice |=> apparent_energy_accum_inc == $past(src.current))
    else $error("accumulator source wrong");

  a_accum_apparent: assert property (
    !eff_r.choice |=> apparent_energy_accum_inc == $past(src.apparent))
    else $error("accumulator not on apparent power");

  // a mixed pair would need two choice bits; there is only one
  a_no_mixed_out: assert property (
    (eff_r.sel_a[1] && eff_r.sel_b[1] && !dis_a && !dis_b)
      |=> pulse_out_a == pulse_out_b)
    else $error("outputs follow different apparent sources");

  a_disable_gate: assert property (
    dis_a |=> !pulse_out_a)
    else $error("disabled pulse a still active");

  a_disable_gate_b: assert property (
    dis_b |=> !pulse_out_b)
    else $error("disabled pulse b still active");

  a_mode_one_write: assert property (
    (hit_one_w && !srst_req) |=> mode_one_r == $past(hwdata[7:0]))
    else $error("mode one write not stored");

  a_rms_crossing: assert property (
    mode_two_r.rms_zx |=> rms_update == $past(zero_cross))
    else $error("rms update not on crossing");

  a_rms_free: assert property (
    !mode_two_r.rms_zx |=> rms_update == $past(rms_ready))
    else $error("free rms update lost");

  a_period_follow: assert property (
    hit_two_w |=> period_or_freq_select == $past(wr_fields.freq))
    else $error("period or frequency select wrong");

  a_wave_follow: assert property (
    hit_two_w |=> waveform_sampling_enable == $past(wr_fields.wave))
    else $error("waveform sampling enable wrong");

  a_mode_two_write: assert property (
    hit_two_w |=> mode_two_r == $past(wr_fields))
    else $error("mode two write not stored");

  // selection moves only on a compute tick or a soft reset request, so a pulse is never split
  a_eff_hold: assert property (
    (!compute_tick && !srst_req) |=> $stable(eff_r))
    else $error("selection changed between compute ticks");

  a_eff_latch: assert property (
    (compute_tick && !srst_req) |=> eff_r == $past(mode_two_r))
    else $error("selection not latched on compute tick");

  a_read_back: assert property (
    (rd_take && hit_two_r) ##1 hready[*2]
      |-> hrdata[7:0] == mode_two_r && hrdata[31:8] == 24'h00_0000)
    else $error("mode two read back wrong");

  a_read_unmapped: assert property (
    (rd_take && !hit_one_r && !hit_two_r)
      |=> hrdata == eomc_pkg::RDATA_ZERO)
    else $error("unmapped read not zero");

  a_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");

  c_write_two: cover property (
    hit_two_w ##1 compute_tick);

  c_soft_reset: cover property (
    srst_req);

  c_current_out: cover property (
    eff_r.choice && eff_r.sel_b[1] && pulse_out_b);

  c_read_two: cover property (
    rd_take && hit_two_r);

  c_both_apparent: cover property (
    eff_r.sel_a[1] && eff_r.sel_b[1] && !dis_a && !dis_b);

endmodule : eomc_regs

// [rtl/eomc_pkg.sv]
// Notes on behaviour
// - pulse b selector bits 7:6, reset 01
// - b: 00 active, 01 reactive, 1x apparent/current
// - pulse a selector bits 5:4, reset 00
// - choice 0: 1x selectors follow apparent power
// - choice 1: 1x selectors follow rms current
// - bit 3 also picks apparent accumulator source
// - no mixed apparent/current across both outputs
// - bit 2 syncs rms updates to crossings
// - bit 1: period 0, frequency 1
// - bit 0 enables waveform sampling, reset 0
// - mode one disable bits gate outputs, reset 1
// - soft reset bit restores register defaults
package eomc_pkg;

  localparam int unsigned ADDR_W = 8;
  // printed offsets are word indices; byte address is four times
  localparam logic [7:0] MODE_ONE_IDX = 8'h0b;
  localparam logic [7:0] MODE_TWO_IDX = 8'h0c;

  localparam logic [7:0] MODE_ONE_RST = 8'h06;
  localparam logic [7:0] MODE_TWO_RST = 8'h40;

  localparam int unsigned M1_SRST_BIT = 7;
  localparam int unsigned M1_DISB_BIT = 2;
  localparam int unsigned M1_DISA_BIT = 1;

  localparam logic [1:0] SEL_ACTIVE   = 2'h0;
  localparam logic [1:0] SEL_REACTIVE = 2'h1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] sel_b;
    logic [1:0] sel_a;
    logic       choice;
    logic       rms_zx;
    logic       freq;
    logic       wave;
  } eomc_mode_two_type;

  typedef struct packed {
    logic active;
    logic reactive;
    logic apparent;
    logic current;
  } eomc_src_type;

endpackage : eomc_pkg

// [tb/eomc_tb.sv]
`timescale 1ns/1ns
module tb;
  localparam logic [7:0] A1 = eomc_pkg::MODE_ONE_IDX << 2;
  localparam logic [7:0] A2 = eomc_pkg::MODE_TWO_IDX << 2;
  logic                   hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic                   compute_tick, zero_cross, rms_ready, seen;
  logic                   pa, pb, acc, rms_upd, pf_sel, wave_en, srst;
  logic [7:0]             haddr;
  logic [1:0]             htrans;
  logic [31:0]            hwdata, hrdata, q;
  logic [3:0]             v;
  eomc_pkg::eomc_src_type src;
  int                     err_count, checked;

  eomc_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .compute_tick(compute_tick),
    .src(src), .zero_cross(zero_cross), .rms_ready(rms_ready),
    .pulse_out_a(pa), .pulse_out_b(pb), .apparent_energy_accum_inc(acc),
    .rms_update(rms_upd), .period_or_freq_select(pf_sel),
    .waveform_sampling_enable(wave_en), .engine_soft_reset(srst));

  always #10 hclk = ~hclk;

  task summarize;
    $display("compares %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      err_count++;
      summarize();
    end
  endtask : rdy

  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= eomc_pkg::HTRANS_NONSEQ;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    rdy();
    q = hrdata;
  endtask : bus

  task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h00_0000, e}, q);
    chk("hresp", 0, hresp);
  endtask : rd

  // outputs are registered, so look one edge after driving
  task step(input logic [3:0] s, input logic zc, input logic rr);
    @(posedge hclk);
    src <= s;
    zero_cross <= zc;
    rms_ready <= rr;
    @(posedge hclk);
    src <= 4'h0;
    zero_cross <= 1'b0;
    rms_ready <= 1'b0;
    #1;
  endtask : step

  task tick;
    @(posedge hclk);
    compute_tick <= 1'b1;
    @(posedge hclk);
    compute_tick <= 1'b0;
  endtask : tick

  function logic pick(input logic [1:0] s, input logic c, input logic [3:0] x);
    if (s == 2'h0)
      return x[3];
    if (s == 2'h1)
      return x[2];
    return c ? x[0] : x[1];
  endfunction : pick

  task t_reset;
    rd(A2, 8'h40, "mode_two");
    rd(A1, 8'h06, "mode_one");
    rd(8'h3c, 8'h00, "unmapped");
    step(4'hf, 1'b0, 1'b0);
    chk("disabled_ab", 0, {pa, pb, wave_en, pf_sel});
  endtask : t_reset

  task t_sel;
    bus(1'b1, A1, 8'h00);
    bus(1'b1, A2, 8'h10);
    step(4'h8, 1'b0, 1'b0);
    chk("sel_unlatched", 1, pa);
    for (int k = 0; k < 32; k++)
    begin
      bus(1'b1, A2, {k[4:0], 3'b000});
      rd(A2, {k[4:0], 3'b000}, "mode_two_rw");
      tick();
      for (int i = 0; i < 4; i++)
      begin
        v = 4'(4'h1 << i);
        step(v, 1'b0, 1'b0);
        chk("pulse_a", pick(k[2:1], k[0], v), pa);
        chk("pulse_b", pick(k[4:3], k[0], v), pb);
        chk("accum", k[0] ? v[0] : v[1], acc);
      end
    end
  endtask : t_sel

  task t_bits;
    for (int k = 0; k < 8; k++)
    begin
      bus(1'b1, A2, {5'h00, k[2:0]});
      step(4'h0, 1'b1, 1'b0);
      chk("rms_on_zx", k[2], rms_upd);
      chk("line_period_result", k[1], pf_sel);
      chk("wave", k[0], wave_en);
      step(4'h0, 1'b0, 1'b1);
      chk("rms_free", !k[2], rms_upd);
    end
  endtask : t_bits

  task t_srst;
    bus(1'b1, A2, 8'hff);
    bus(1'b1, A1, 8'h80);
    seen = 1'b0;
    repeat (4)
    begin
      #1;
      if (srst === 1'b1)
        seen = 1'b1;
      @(posedge hclk);
    end
    chk("soft_reset", 1, seen);
    rd(A2, 8'h40, "mode_two_srst");
    rd(A1, 8'h06, "mode_one_srst");
  endtask : t_srst

  initial
  begin
    {hclk, hresetn, hsel, hwrite, compute_tick, zero_cross} = 6'h00;
    {rms_ready, haddr, htrans, hwdata, src} = 0;
    err_count = 0;
    checked = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_sel();
    t_bits();
    t_srst();
    summarize();
  end
endmodule : tb
